/* rtl/mic_pkg.sv */
/*
  Shared constants and types of the maskable interrupt control block:
  register indices, field positions, reset values and the sequence states.
  Assumes a 32-bit APB slave with word-indexed registers.
*/
package mic_pkg;

  // ----------------------------------------------------------------
  // Register map (word indices, byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int          ADDR_W   = 12;
  localparam int          IDX_W    = 10;
  localparam logic [9:0]  INFO_IDX = 10'h000;
  localparam logic [9:0]  FLAG_IDX = 10'h040;
  localparam logic [9:0]  VTB_IDX  = 10'h041;
  localparam logic [9:0]  CTRL_IDX = 10'h055;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          LVL_LSB  = 0;
  localparam int          REQ_BIT  = 3;
  localparam int          FLG_D    = 2;
  localparam int          FLG_I    = 6;
  localparam int          FLG_U    = 7;
  localparam int          IPL_LSB  = 12;
  localparam int          VEC_SH   = 2;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [19:0] VTB_RST  = 20'h00000;
  localparam logic [19:0] INFO_ADR = 20'h00000;
  localparam logic [5:0]  SW_U_LO  = 6'h20;
  localparam logic [5:0]  SRC_BASE = 6'h04;

  typedef struct packed {
    logic [5:0] num;
    logic [2:0] lvl;
  } mic_info_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INFO,
    ST_SAVE,
    ST_CLR,
    ST_PUSH_F,
    ST_PUSH_P,
    ST_IPL,
    ST_JUMP
  } mic_state_t;

endpackage

/* rtl/mic_resolver.sv */
/*
  Priority resolution among the maskable sources.
  Purely combinational; the caller registers the result.
*/
module mic_resolver #(
  parameter int NUM_SRC = 8,
  parameter int SEL_W   = 3
) (
  input  wire logic [NUM_SRC-1:0]   req_i,
  input  wire logic [3*NUM_SRC-1:0] lvl_i,
  input  wire logic [2:0]           ipl_i,
  output logic                      any_o,
  output logic [SEL_W-1:0]          idx_o,
  output logic [2:0]                lvl_o
);

  logic [NUM_SRC-1:0] elig;

  // ----------------------------------------------------------------
  // Eligibility per source
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_SRC; i++)
  begin : g_elig
    assign elig[i] = req_i[i] & (lvl_i[3*i +: 3] > ipl_i); // R6 R7
  end

  // ----------------------------------------------------------------
  // Winner search
  // ----------------------------------------------------------------
  // Downward walk with >= lets the lower index win a level tie
  always_comb
  begin
    any_o = 1'b0;
    idx_o = '0;
    lvl_o = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (elig[i] && (lvl_i[3*i +: 3] >= lvl_o))
      begin
        any_o = 1'b1;
        idx_o = SEL_W'(i); // R22
        lvl_o = lvl_i[3*i +: 3];
      end
    end
  end

endmodule

/* rtl/mic_top.sv */
/*
  Maskable interrupt control: per-source control registers, flag register,
  vector table base, resolution and the CPU interrupt-entry sequence.
  Assumes an APB master on sys_clk_i, request pulses from logic on the same
  clock, and a CPU core that marks instruction boundaries and performs the
  stack writes and vector fetch that this block announces.
*/
// The APB interface to the registers was chosen for this implementation.

// Summary of operation
// R1: Global enable gates maskables; resets to zero.
// R2: Source request sets its pending bit.
// R3: Hardware clears pending bit in the first step, before vectoring.
// R4: Writing zero clears pending; one ignored.
// R5: Three-bit level per source; zero disables.
// R6: Eligible only if level above processor level.
// R7: Processor level seven blocks every maskable.
// R8: Accept needs enable, pending, level above.
// R9: Enable, requests, levels, processor level independent.
// R10: Per-source control, flag register holds rest.
// R11: Software interrupts bypass the maskable gating.
// R12: Software rewrites control only when quiet.
// R13: Software waits before re-enabling after rewrite.
// R14: Use read-modify-write; coincident request kept.
// R15: Sequence starts cycle after instruction completes.
// R16: String instructions are suspended for interrupts.
// R17: First step reads info, then clears request.
// R18: Flag copied into hidden temporary register.
// R19: Clear enable, debug, stack select flags; stack select kept for software numbers from 32.
// R20: Push temporary flag copy, then program counter.
// R21: Load accepted level into processor level.
// R22: Level tie goes to fixed hardware priority.
// R23: Vector from base plus four-byte entry.
// R24: Winner number and level held registered.
module mic_top #(
  parameter int         NUM_SRC  = 8,
  parameter logic [5:0] SRC_NUM0 = mic_pkg::SRC_BASE
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rstn_i,
  // APB slave
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [mic_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic [31:0]                    prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  // Peripheral requests
  input  wire logic [NUM_SRC-1:0]        irq_req_i,
  // CPU pipeline
  input  wire logic                      instr_done_i,
  input  wire logic                      string_instr_i,
  input  wire logic                      sw_int_i,
  input  wire logic [5:0]                sw_num_i,
  input  wire logic [19:0]               pc_i,
  input  wire logic                      reti_i,
  input  wire logic [15:0]               reti_flag_i,
  output logic                           seq_busy_o,
  output logic                           suspend_o,
  output logic                           info_rd_o,
  output mic_pkg::mic_info_t             info_o,
  output logic                           push_o,
  output logic [19:0]                    push_data_o,
  output logic                           jump_o,
  output logic [19:0]                    vec_addr_o,
  output logic [15:0]                    flag_o
);

  localparam int SEL_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_SRC < 2 || NUM_SRC > 28 || 32'(SRC_NUM0) + NUM_SRC > 32)
  begin : g_bad_cfg
    $error("mic_top: NUM_SRC or SRC_NUM0 out of range");
  end
  if (mic_pkg::IDX_W + 2 != mic_pkg::ADDR_W)
  begin : g_bad_map
    $error("mic_top: word index width does not match address width");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0]   req_q;
  logic [3*NUM_SRC-1:0] lvl_q;
  logic [15:0]          flag;
  logic [15:0]          next_flag;
  logic [15:0]          tmp_flag;
  logic [19:0]          vtb;
  logic [19:0]          pc_q;
  mic_pkg::mic_info_t   info_q;
  logic                 is_sw_q;
  logic [SEL_W-1:0]     win_q;
  mic_pkg::mic_state_t  state;
  mic_pkg::mic_state_t  next_state;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire [9:0]  idx      = paddr_i[11:2];
  wire        setup    = psel_i & ~penable_i;
  wire        wr_en    = psel_i & penable_i & pwrite_i;
  wire [9:0]  ctrl_off = idx - mic_pkg::CTRL_IDX;
  wire        ctrl_hit = (idx >= mic_pkg::CTRL_IDX) && (ctrl_off < 10'(NUM_SRC));
  wire        flag_hit = (idx == mic_pkg::FLAG_IDX);
  wire        vtb_hit  = (idx == mic_pkg::VTB_IDX);
  wire        info_hit = (idx == mic_pkg::INFO_IDX);
  wire        hit      = ctrl_hit | flag_hit | vtb_hit | info_hit;
  wire        busy     = (state != mic_pkg::ST_IDLE);
  // Flag writes are ignored while the entry sequence owns the flags
  wire        wr_flag  = wr_en & flag_hit & ~busy;
  wire        wr_vtb   = wr_en & vtb_hit;
  wire [2:0]  processor_priority_level      = flag[mic_pkg::IPL_LSB +: 3];
  wire [SEL_W-1:0] sel = ctrl_off[SEL_W-1:0];

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;

  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (flag_hit)
      rd_word = {16'h0000, flag};
    else if (vtb_hit)
      rd_word = {12'h000, vtb};
    else if (info_hit)
      rd_word = {23'h00_0000, info_q};
    else if (ctrl_hit)
      rd_word = {28'h000_0000, req_q[sel], lvl_q[3*sel +: 3]}; // R10
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      prdata_o <= 32'h0000_0000;
    else if (setup)
      prdata_o <= rd_word;
  end

  // ----------------------------------------------------------------
  // Per-source control registers
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] hw_clr;
  logic [NUM_SRC-1:0] wr_ctrl;

  for (genvar i = 0; i < NUM_SRC; i++)
  begin : g_src
    assign wr_ctrl[i] = wr_en & ctrl_hit & (sel == SEL_W'(i));
    assign hw_clr[i]  = (state == mic_pkg::ST_INFO) & ~is_sw_q & (win_q == SEL_W'(i)); // R3 R17

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
      if (!rstn_i)
      begin
        req_q[i]         <= 1'b0;
        lvl_q[3*i +: 3]  <= 3'h0;
      end
      else
      begin
        if (wr_ctrl[i])
          lvl_q[3*i +: 3] <= pwdata_i[mic_pkg::LVL_LSB +: 3]; // R5 R9
        // A new request beats any clear in the same cycle
        if (irq_req_i[i])
          req_q[i] <= 1'b1; // R2 R14
        else if (hw_clr[i] | (wr_ctrl[i] & ~pwdata_i[mic_pkg::REQ_BIT]))
          req_q[i] <= 1'b0; // R4
      end
    end
  end

  // ----------------------------------------------------------------
  // Resolution and acceptance
  // ----------------------------------------------------------------
  logic             any_elig;
  logic [SEL_W-1:0] win_idx;
  logic [2:0]       win_lvl;

  mic_resolver #(
    .NUM_SRC (NUM_SRC),
    .SEL_W   (SEL_W)
  ) u_resolver (
    .req_i (req_q),
    .lvl_i (lvl_q),
    .ipl_i (processor_priority_level),
    .any_o (any_elig),
    .idx_o (win_idx),
    .lvl_o (win_lvl)
  );

  // Maskable acceptance at a boundary or inside a suspendable string op
  wire boundary  = instr_done_i | string_instr_i; // R16
  wire mask_take = flag[mic_pkg::FLG_I] & any_elig & boundary; // R1 R8
  wire sw_take   = sw_int_i & instr_done_i; // R11
  wire take      = ~busy & (sw_take | mask_take); // R15
  wire sw_pick   = sw_take;

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      info_q  <= '0;
      is_sw_q <= 1'b0;
      win_q   <= '0;
      pc_q    <= 20'h00000;
    end
    else if (take)
    begin
      is_sw_q <= sw_pick;
      win_q   <= win_idx;
      pc_q    <= pc_i;
      if (sw_pick)
        info_q <= '{num: sw_num_i, lvl: processor_priority_level};
      else
        info_q <= '{num: SRC_NUM0 + 6'(win_idx), lvl: win_lvl}; // R24
    end
  end

  // ----------------------------------------------------------------
  // Entry sequence
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      mic_pkg::ST_IDLE:   if (take) next_state = mic_pkg::ST_INFO;
      mic_pkg::ST_INFO:   next_state = mic_pkg::ST_SAVE;
      mic_pkg::ST_SAVE:   next_state = mic_pkg::ST_CLR;
      mic_pkg::ST_CLR:    next_state = mic_pkg::ST_PUSH_F;
      mic_pkg::ST_PUSH_F: next_state = mic_pkg::ST_PUSH_P;
      mic_pkg::ST_PUSH_P: next_state = mic_pkg::ST_IPL;
      mic_pkg::ST_IPL:    next_state = mic_pkg::ST_JUMP;
      mic_pkg::ST_JUMP:   next_state = mic_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state <= mic_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Flag register, hidden copy and vector table base
  // ----------------------------------------------------------------
  wire keep_u = is_sw_q & (info_q.num >= mic_pkg::SW_U_LO);

  always_comb
  begin
    next_flag = flag;
    if (wr_flag)
      next_flag = pwdata_i[15:0]; // R9 R10
    if (reti_i && !busy)
      next_flag = reti_flag_i;
    if (state == mic_pkg::ST_CLR)
    begin
      next_flag[mic_pkg::FLG_I] = 1'b0; // R19
      next_flag[mic_pkg::FLG_D] = 1'b0;
      if (!keep_u)
        next_flag[mic_pkg::FLG_U] = 1'b0;
    end
    // Software interrupts leave the processor level alone
    if (state == mic_pkg::ST_IPL && !is_sw_q)
      next_flag[mic_pkg::IPL_LSB +: 3] = info_q.lvl; // R21
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      flag <= mic_pkg::FLAG_RST; // R1
    else
      flag <= next_flag;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tmp_flag <= 16'h0000;
    else if (state == mic_pkg::ST_SAVE)
      tmp_flag <= flag; // R18
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      vtb <= mic_pkg::VTB_RST;
    else if (wr_vtb)
      vtb <= pwdata_i[19:0];
  end

  // ----------------------------------------------------------------
  // CPU-facing outputs
  // ----------------------------------------------------------------
  // Entries are 4 bytes and numbers stay below 64: table spans 256 bytes
  wire [19:0] vec_next = vtb + {12'h000, info_q.num, 2'b00}; // R23

  // Step pulses: one cycle each, except push_o, high for both push steps
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      suspend_o <= 1'b0;
      info_rd_o <= 1'b0;
      push_o    <= 1'b0;
      jump_o    <= 1'b0;
    end
    else
    begin
      suspend_o <= take & ~sw_pick & ~instr_done_i & string_instr_i; // R16
      info_rd_o <= (state == mic_pkg::ST_INFO); // R17
      push_o    <= (state == mic_pkg::ST_PUSH_F) | (state == mic_pkg::ST_PUSH_P);
      jump_o    <= (state == mic_pkg::ST_JUMP);
    end
  end

  // Data words load on their own step only, so they stand until the next sequence
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      push_data_o <= 20'h00000;
      vec_addr_o  <= 20'h00000;
    end
    else
    begin
      if (state == mic_pkg::ST_PUSH_F)
        push_data_o <= {4'h0, tmp_flag}; // R20
      else if (state == mic_pkg::ST_PUSH_P)
        push_data_o <= pc_q;
      if (state == mic_pkg::ST_JUMP)
        vec_addr_o <= vec_next;
    end
  end

  assign seq_busy_o = busy;
  assign info_o     = info_q;
  assign flag_o     = flag;

endmodule

/* tb/mic_sva.sv */
/*
  Port checks of the interrupt control top.
  Assumes one clock domain and a bind onto mic_top.
*/
module mic_sva (
  input wire logic                       sys_clk_i,
  input wire logic                       rstn_i,
  input wire logic                       psel_i,
  input wire logic                       penable_i,
  input wire logic [mic_pkg::ADDR_W-1:0] paddr_i,
  input wire logic                       instr_done_i,
  input wire logic                       string_instr_i,
  input wire logic                       sw_int_i,
  input wire logic                       pslverr_o,
  input wire logic                       seq_busy_o,
  input wire logic                       suspend_o,
  input wire logic                       info_rd_o,
  input wire logic                       push_o,
  input wire logic [19:0]                push_data_o,
  input wire logic [19:0]                pc_i,
  input wire logic                       jump_o,
  input wire logic [15:0]                flag_o,
  input wire mic_pkg::mic_info_t         info_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // ------------------------------
  // Entry sequence, acceptance and APB error
  // ------------------------------
  sequence s_accept;
    $rose(seq_busy_o);
  endsequence
  sequence s_pushes;
    ##3 push_o ##1 push_o ##1 !push_o ##1 jump_o;
  endsequence
  a_info_step: assert property (s_accept |-> !info_rd_o ##1 info_rd_o)
    else $error("info read step misplaced");
  a_push_order: assert property (info_rd_o |-> s_pushes)
    else $error("push or jump step misplaced");
  a_flag_copy: assert property (info_rd_o |-> ##3 push_data_o == {4'h0, $past(flag_o, 3)})
    else $error("pushed flag copy wrong");
  a_pc_push: assert property (info_rd_o |-> ##4 push_data_o == $past(pc_i, 6))
    else $error("pushed program counter wrong");
  a_flags_cleared: assert property (info_rd_o |-> ##2 !flag_o[mic_pkg::FLG_I] && !flag_o[mic_pkg::FLG_D])
    else $error("enable or debug flag not cleared");
  a_ipl_loaded: assert property (jump_o |-> flag_o[mic_pkg::IPL_LSB +: 3] == info_o.lvl)
    else $error("processor level not loaded");
  a_gate_maskable: assert property ($rose(seq_busy_o) && !$past(sw_int_i && instr_done_i) |->
    $past(flag_o[mic_pkg::FLG_I]) && info_o.lvl > $past(flag_o[mic_pkg::IPL_LSB +: 3]))
    else $error("maskable accepted without its conditions");
  a_start_boundary: assert property (s_accept |-> $past(instr_done_i || string_instr_i))
    else $error("sequence started off a boundary");
  a_string_suspend: assert property ($rose(seq_busy_o) && $past(string_instr_i && !instr_done_i && !sw_int_i)
    |-> suspend_o)
    else $error("string instruction not suspended");
  a_ipl7_blocks: assert property (!seq_busy_o && flag_o[mic_pkg::IPL_LSB +: 3] == 3'h7
    && !(sw_int_i && instr_done_i) |=> !seq_busy_o)
    else $error("accepted at processor level seven");
  a_unmapped_err: assert property (psel_i && penable_i && paddr_i[11:2] == 10'h042 |-> pslverr_o)
    else $error("unmapped access not refused");
endmodule

bind mic_top mic_sva i_sva (.sys_clk_i, .rstn_i, .psel_i, .penable_i, .paddr_i, .instr_done_i,
  .string_instr_i, .sw_int_i, .pslverr_o, .seq_busy_o, .suspend_o, .info_rd_o, .push_o,
  .push_data_o, .pc_i, .jump_o, .flag_o, .info_o);

/* tb/mic_cpu_model.sv */
/*
  Behavioural CPU pipeline beside the interrupt control block.
  Assumes the block's clock and reset; returns at once when asked.
*/
module mic_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        slow_i,
  input  wire logic        str_i,
  input  wire logic        ret_en_i,
  input  wire logic        busy_i,
  input  wire logic        push_i,
  input  wire logic        jump_i,
  input  wire logic [19:0] push_data_i,
  input  wire logic [19:0] vec_addr_i,
  output logic             instr_done_o,
  output logic             string_instr_o,
  output logic [19:0]      pc_o,
  output logic             reti_o,
  output logic [15:0]      reti_flag_o
);
  logic [1:0] cnt;
  logic       first;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt <= 2'h0;
      first <= 1'b1;
      instr_done_o <= 1'b0;
      string_instr_o <= 1'b0;
      pc_o <= 20'h00000;
      reti_o <= 1'b0;
      reti_flag_o <= 16'h0000;
    end
    else
    begin
      cnt <= cnt + 2'h1;
      // A string instruction never completes by itself
      instr_done_o <= !busy_i && !str_i && (!slow_i || cnt == 2'h3);
      string_instr_o <= str_i && !busy_i;
      pc_o <= jump_i ? vec_addr_i : pc_o + {19'h00000, instr_done_o};
      first <= push_i ? !first : first;
      if (push_i && first)
        reti_flag_o <= push_data_i[15:0];
      else if (reti_o)
        reti_flag_o <= ~reti_flag_o;
      reti_o <= ret_en_i && jump_i;
    end
  end
endmodule

/* tb/mic_top_test.sv */
/*
  Self-checking bench of the interrupt control block.
  Assumes mic_cpu_model as the CPU and the bound checker.
*/
module mic_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NS = 8;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        sw = 1'b0, slow = 1'b0, str = 1'b0, ret = 1'b0, sus = 1'b0, err, acc;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h00000000, rd, prdata;
  logic [7:0]  irq = 8'h00;
  logic [5:0]  swn = 6'h00;
  logic        pready, pslverr, busy, susp, inford, push, jump, done, stri, reti;
  logic [19:0] pdat, vec, pc, vc, vtb;
  logic [15:0] flag, rflag, fc;
  logic [9:0]  ci;
  mic_pkg::mic_info_t info;
  int          mismatches = 0, num_checks = 0, seed = 99447, i, p, l, n;

  mic_top #(.NUM_SRC(NS)) i_dut (.sys_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_req_i(irq), .instr_done_i(done), .string_instr_i(stri),
    .sw_int_i(sw), .sw_num_i(swn), .pc_i(pc), .reti_i(reti), .reti_flag_i(rflag),
    .seq_busy_o(busy), .suspend_o(susp), .info_rd_o(inford), .info_o(info), .push_o(push),
    .push_data_o(pdat), .jump_o(jump), .vec_addr_o(vec), .flag_o(flag));
  mic_cpu_model i_cpu (.clk_i(clk), .rstn_i(rstn), .slow_i(slow), .str_i(str), .ret_en_i(ret),
    .busy_i(busy), .push_i(push), .jump_i(jump), .push_data_i(pdat), .vec_addr_i(vec),
    .instr_done_o(done), .string_instr_o(stri), .pc_o(pc), .reti_o(reti), .reti_flag_o(rflag));

  initial forever #4 clk = ~clk;
  always @(posedge clk) if (susp === 1'b1) sus <= 1'b1;

  function automatic logic [11:0] ad(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction
  function automatic logic [31:0] fl(input logic ie, input logic u, input logic [2:0] processor_priority_level);
    return {17'h00000, processor_priority_level, 4'h0, u, ie, 6'h00};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [7:0] m);
    irq <= m;
    @(posedge clk);
    irq <= 8'h00;
  endtask
  // Samples at the falling edge, leaves just after a rising one
  task automatic run_seq(output logic a);
    int k;
    a = 1'b0;
    for (k = 0; k < 30; k++)
    begin
      @(negedge clk);
      if (busy === 1'b1) a = 1'b1;
      vc = vec;
      fc = flag;
      if (jump === 1'b1) break;
    end
    @(posedge clk);
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #400000;
    mismatches++;
    give_verdict;
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, ad(mic_pkg::FLAG_IDX), 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ad(10'h042), 32'h0);
    chk(32'(err), 32'h1);
    vtb = 20'($random(seed));
    apb(1'b1, ad(mic_pkg::VTB_IDX), {12'h000, vtb});
    apb(1'b1, ad(mic_pkg::FLAG_IDX), fl(1'b0, 1'b0, 3'h5));
    apb(1'b1, ad(mic_pkg::CTRL_IDX), 32'h3);
    apb(1'b0, ad(mic_pkg::FLAG_IDX), 32'h0);
    chk(rd, fl(1'b0, 1'b0, 3'h5));
    for (p = 0; p < 8; p++)
      for (l = 0; l < 8; l++)
      begin
        i = {$random(seed)} % NS;
        ci = mic_pkg::CTRL_IDX + 10'(i);
        slow <= p[0];
        apb(1'b1, ad(mic_pkg::FLAG_IDX), fl(1'b0, 1'b0, 3'(p)));
        apb(1'b1, ad(ci), 32'(l));
        pulse(8'h01 << i);
        apb(1'b0, ad(ci), 32'h0);
        chk(rd, 32'(l) | 32'h8);
        apb(1'b1, ad(mic_pkg::FLAG_IDX), fl(1'b1, 1'b0, 3'(p)));
        run_seq(acc);
        chk(32'(acc), 32'(l > p));
        if (acc)
        begin
          chk(32'(info), 32'({mic_pkg::SRC_BASE + 6'(i), 3'(l)}));
          chk(32'(vc), 32'(20'(vtb + 20'((4 + i) * 4))));
          chk(32'(fc), fl(1'b0, 1'b0, 3'(l)));
        end
        apb(1'b0, ad(ci), 32'h0);
        chk(rd, acc ? 32'(l) : 32'(l) | 32'h8);
        apb(1'b1, ad(ci), 32'h0);
        apb(1'b1, ad(ci), 32'h8);
        apb(1'b0, ad(ci), 32'h0);
        chk(rd, 32'h0);
      end
    str <= 1'b1;
    apb(1'b1, ad(mic_pkg::FLAG_IDX), fl(1'b0, 1'b0, 3'h0));
    apb(1'b1, ad(mic_pkg::CTRL_IDX + 10'h001), 32'h5);
    apb(1'b1, ad(mic_pkg::CTRL_IDX + 10'h006), 32'h5);
    pulse(8'h42);
    for (n = 1; n < 7; n += 5)
    begin
      apb(1'b1, ad(mic_pkg::FLAG_IDX), fl(1'b1, 1'b0, 3'h0));
      run_seq(acc);
      chk(32'(info.num), 32'(mic_pkg::SRC_BASE + 6'(n)));
    end
    chk(32'(sus), 32'h1);
    str <= 1'b0;
    slow <= 1'b0;
    ret <= 1'b1;
    for (n = 5; n < 50; n += 35)
    begin
      apb(1'b1, ad(mic_pkg::FLAG_IDX), fl(1'b0, 1'b1, 3'h3));
      sw <= 1'b1;
      swn <= 6'(n);
      @(posedge clk);
      sw <= 1'b0;
      run_seq(acc);
      chk(32'(acc), 32'h1);
      chk(32'(info.num), 32'(n));
      chk(32'(fc), fl(1'b0, n >= 32, 3'h3));
      repeat (2) @(posedge clk);
      apb(1'b0, ad(mic_pkg::FLAG_IDX), 32'h0);
      chk(rd, fl(1'b0, 1'b1, 3'h3));
    end
    give_verdict;
  end
endmodule
